/* File: inc/keypad_pkg.sv */
// shared constants and bus carrier for the keypad interrupt block
package keypad_pkg;

  // number of keypad inputs
  localparam int unsigned PIN_COUNT = 8;

  // register address width and data width
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 8;

  // register offsets
  localparam logic [ADDR_WIDTH-1:0] STATUS_CONTROL_OFFSET = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] PIN_ENABLE_OFFSET = 4'h1;

  // status/control field positions
  localparam int unsigned PENDING_BIT = 3;
  localparam int unsigned ACK_BIT = 2;
  localparam int unsigned MASK_BIT = 1;
  localparam int unsigned SENSE_BIT = 0;

  // values after reset
  localparam logic [DATA_WIDTH-1:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] PIN_ENABLE_RESET = 8'h00;
  localparam logic MASK_RESET = 1'b0;
  localparam logic SENSE_RESET = 1'b0;

  // answer to an unmapped read
  localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ = 8'h00;

  // register bus request, all fields sampled on one edge
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic write;
    logic read;
  } bus_request_type;

endpackage

/* File: hdl/keypad_edge_level_interrupt.sv */
// keypad interrupt block: pin enables, shared edge/level latch, status/control register
//
// Operation
// (RQ1) per-pin enable bits gate latch inputs
// (RQ2) enable bit also turns pin pullup on
// (RQ3) latch sets when enabled inputs first fall
// (RQ4) edge mode ignores edge if another low
// (RQ5) level mode holds request while any low
// (RQ6) level mode: clear needs ack and pins high
// (RQ7) vector fetch acknowledge clears the latch
// (RQ8) writing ack one clears; reads zero
// (RQ9) later falling edges set latch again
// (RQ10) reset clears request and sense select
// (RQ11) edge mode: ack clears latch at once
// (RQ12) pending flag readable, ignores mask
// (RQ13) mask one blocks cpu request
// (RQ14) enable bit forces pin to input
// (RQ15) status bits 3..0 laid out, rest zero
// (RQ16) software masks, enables, acks, then unmasks
// (RQ17) level pins need load delay before ack
// (RQ18) active in wait; request wakes cpu
// (RQ19) active in stop; request wakes cpu
// (RQ20) break state protects flag unless enabled
// (RQ21) inputs synchronised, edge from previous sample
// (RQ22) one-cycle vector ack in, level request out
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns

module keypad_edge_level_interrupt #(
  parameter int unsigned PINS = keypad_pkg::PIN_COUNT
) (
  input wire logic clock,
  input wire logic reset,
  input wire keypad_pkg::bus_request_type bus_request,
  output logic [keypad_pkg::DATA_WIDTH-1:0] read_data,
  input wire logic [PINS-1:0] keypad_input_pins,
  input wire logic vector_fetch_ack,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic cpu_request,
  output logic [PINS-1:0] pullup_enable,
  output logic [PINS-1:0] force_input
);

  // pin sampling
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;

  // control and status state
  logic [PINS-1:0] pin_enable_q;
  logic mask_q;
  logic sense_q;
  logic latch_q;
  logic latch_d;
  logic prev_low_q;
  logic pending_q;
  logic pending_d;
  logic cpu_request_q;
  logic [keypad_pkg::DATA_WIDTH-1:0] read_data_q;
  logic [keypad_pkg::DATA_WIDTH-1:0] read_data_d;

  // decoded events
  logic status_write;
  logic enable_write;
  logic ack_write;
  logic sw_ack;
  logic any_ack;
  logic low_any;
  logic edge_seen;

  // two-flop synchroniser per pin
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end else begin
      pin_meta_q <= keypad_input_pins;
      pin_sync_q <= pin_meta_q; // see (RQ21)
    end
  end

  // register write decode
  always_comb begin
    status_write = bus_request.write
      && (bus_request.addr == keypad_pkg::STATUS_CONTROL_OFFSET);
    enable_write = bus_request.write
      && (bus_request.addr == keypad_pkg::PIN_ENABLE_OFFSET);
    ack_write = status_write
      && bus_request.wdata[keypad_pkg::ACK_BIT]; // see (RQ8)
  end

  // software ack is blocked in break unless clears allowed
  always_comb begin
    sw_ack = ack_write
      && (!break_state || break_clear_enable); // see (RQ20)
    any_ack = sw_ack || vector_fetch_ack; // see (RQ7) see (RQ22)
  end

  // pin enable register
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_enable_q <= PINS'(keypad_pkg::PIN_ENABLE_RESET);
    end else if (enable_write) begin
      pin_enable_q <= bus_request.wdata[PINS-1:0]; // see (RQ1)
    end
  end

  // mask and sense select bits
  always_ff @(posedge clock) begin
    if (reset) begin
      mask_q <= keypad_pkg::MASK_RESET;
      sense_q <= keypad_pkg::SENSE_RESET; // see (RQ10)
    end else if (status_write) begin
      mask_q <= bus_request.wdata[keypad_pkg::MASK_BIT];
      sense_q <= bus_request.wdata[keypad_pkg::SENSE_BIT];
    end
  end

  // combined low detect over enabled pins only
  always_comb begin
    low_any = |(~pin_sync_q & pin_enable_q); // see (RQ1)
    edge_seen = low_any && !prev_low_q; // see (RQ3) see (RQ4)
  end

  // previous combined low sample
  always_ff @(posedge clock) begin
    if (reset) begin
      prev_low_q <= 1'b0;
    end else begin
      prev_low_q <= low_any; // see (RQ21)
    end
  end

  // shared latch, a new edge wins over an ack
  always_comb begin
    latch_d = latch_q;
    if (edge_seen) begin
      latch_d = 1'b1; // see (RQ3) see (RQ9)
    end else if (any_ack) begin
      latch_d = 1'b0; // see (RQ11)
    end
  end

  // latch state
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_q <= 1'b0; // see (RQ10)
    end else begin
      latch_q <= latch_d;
    end
  end

  // level mode keeps request up while any enabled pin is low
  always_comb begin
    pending_d = latch_d
      || (sense_q && low_any); // see (RQ5) see (RQ6)
  end

  // pending flag, independent of mask
  always_ff @(posedge clock) begin
    if (reset) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= pending_d; // see (RQ12)
    end
  end

  // masked cpu request, also the wake source in wait and stop
  always_ff @(posedge clock) begin
    if (reset) begin
      cpu_request_q <= 1'b0; // see (RQ10)
    end else begin
      cpu_request_q <= pending_d && !mask_q; // see (RQ13) see (RQ18) see (RQ19)
    end
  end

  // read mux, ack and upper bits read zero
  always_comb begin
    read_data_d = keypad_pkg::UNMAPPED_READ;
    if (bus_request.read) begin
      if (bus_request.addr == keypad_pkg::STATUS_CONTROL_OFFSET) begin
        read_data_d[keypad_pkg::PENDING_BIT] = pending_q; // see (RQ12) see (RQ15)
        read_data_d[keypad_pkg::MASK_BIT] = mask_q;
        read_data_d[keypad_pkg::SENSE_BIT] = sense_q;
      end else if (bus_request.addr == keypad_pkg::PIN_ENABLE_OFFSET) begin
        read_data_d = keypad_pkg::DATA_WIDTH'(pin_enable_q);
      end
    end
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      read_data_q <= keypad_pkg::STATUS_CONTROL_RESET;
    end else begin
      read_data_q <= read_data_d;
    end
  end

  // outputs straight from flops
  assign read_data = read_data_q;
  assign cpu_request = cpu_request_q;
  assign pullup_enable = pin_enable_q; // see (RQ2)
  assign force_input = pin_enable_q; // see (RQ14)

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // named steps
  sequence s_sw_ack;
    ack_write && (!break_state || break_clear_enable);
  endsequence

  sequence s_any_ack;
    s_sw_ack or vector_fetch_ack;
  endsequence

  sequence s_status_read;
    bus_request.read && (bus_request.addr == keypad_pkg::STATUS_CONTROL_OFFSET);
  endsequence

  sequence s_enable_write;
    enable_write;
  endsequence

  property p_mask_blocks;
    mask_q && !status_write |=> !cpu_request ##1 !cpu_request || !mask_q;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) // see (RQ13)
    else $error("masked latch raised cpu request");

  property p_unmasked_passes;
    !mask_q && !status_write && pending_d |=> cpu_request;
  endproperty
  a_unmasked_passes: assert property (p_unmasked_passes) // see (RQ13)
    else $error("unmasked pending did not reach cpu");

  property p_edge_sets;
    edge_seen |=> pending_q ##0 latch_q;
  endproperty
  a_edge_sets: assert property (p_edge_sets) // see (RQ3)
    else $error("falling edge did not set latch");

  property p_edge_blocked;
    !sense_q && prev_low_q && !latch_q |=> !latch_q;
  endproperty
  a_edge_blocked: assert property (p_edge_blocked) // see (RQ4)
    else $error("edge set latch while another pin low");

  property p_level_holds;
    sense_q && low_any |=> pending_q;
  endproperty
  a_level_holds: assert property (p_level_holds) // see (RQ5)
    else $error("level mode dropped request while pin low");

  property p_edge_ack_clears;
    s_any_ack ##0 (!edge_seen && !sense_q) |=> !pending_q;
  endproperty
  a_edge_ack_clears: assert property (p_edge_ack_clears) // see (RQ11)
    else $error("edge mode ack did not clear latch");

  property p_level_clear;
    sense_q && !low_any && !status_write ##0 s_any_ack ##0 !edge_seen |=> !pending_q;
  endproperty
  a_level_clear: assert property (p_level_clear) // see (RQ6)
    else $error("level mode request not cleared after ack with pins high");

  property p_ack_reads_zero;
    s_status_read |=> read_data[keypad_pkg::ACK_BIT] == 1'b0
      && read_data[7:4] == 4'h0;
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) // see (RQ15)
    else $error("status read shows ack or upper bits");

  property p_flag_read;
    s_status_read |=> read_data[keypad_pkg::PENDING_BIT] == $past(pending_q);
  endproperty
  a_flag_read: assert property (p_flag_read) // see (RQ12)
    else $error("pending flag read wrong");

  property p_break_protect;
    latch_q && ack_write && break_state && !break_clear_enable && !vector_fetch_ack |=> latch_q;
  endproperty
  a_break_protect: assert property (p_break_protect) // see (RQ20)
    else $error("flag cleared in protected break state");

  property p_enable_write;
    s_enable_write |=> pullup_enable == $past(bus_request.wdata[PINS-1:0])
      && force_input == pullup_enable;
  endproperty
  a_enable_write: assert property (p_enable_write) // see (RQ2)
    else $error("pin enable write did not reach pullup");

  property p_reset_clears;
    disable iff (1'b0) reset |=> !cpu_request && !sense_q && !latch_q;
  endproperty
  a_reset_clears: assert property (p_reset_clears) // see (RQ10)
    else $error("reset left request or sense select set");

  // extra steps: a vector ack alone, and a fall one cycle after any ack
  sequence s_vector_ack;
    vector_fetch_ack;
  endsequence

  sequence s_fall_after_ack;
    s_any_ack ##1 edge_seen;
  endsequence

  // vector fetch ack clears the latch unless a new edge lands with it
  property p_vector_clears;
    s_vector_ack ##0 !edge_seen |=> !latch_q;
  endproperty
  a_vector_clears: assert property (p_vector_clears) // see (RQ7)
    else $error("vector fetch ack did not clear latch");

  // an ack does not swallow a later fall
  property p_rearm;
    s_fall_after_ack |=> latch_q && pending_q;
  endproperty
  a_rearm: assert property (p_rearm) // see (RQ9)
    else $error("fall after ack did not set latch again");

  // with no pin enabled the latch cannot rise
  property p_disabled_quiet;
    pin_enable_q == '0 |=> !$rose(latch_q);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // see (RQ1)
    else $error("latch rose with every pin disabled");

  // cpu request never stands without the pending flag behind it
  property p_request_has_flag;
    cpu_request |-> pending_q;
  endproperty
  a_request_has_flag: assert property (p_request_has_flag) // see (RQ22)
    else $error("cpu request high with no pending flag");

  // mask writes leave the flag alone in edge mode
  property p_flag_ignores_mask;
    !sense_q && !edge_seen && !any_ack |=> pending_q == $past(latch_q);
  endproperty
  a_flag_ignores_mask: assert property (p_flag_ignores_mask) // see (RQ12)
    else $error("pending flag moved without edge or ack");

  // second flop copies the first, except across a reset
  property p_sync_chain;
    !$past(reset) |-> pin_sync_q == $past(pin_meta_q);
  endproperty
  a_sync_chain: assert property (p_sync_chain) // see (RQ21)
    else $error("synchroniser skipped a stage");

  // edge mode: any ack with no new edge in the same cycle drops the cpu request next cycle
  property p_edge_ack_drops;
    s_any_ack ##0 (!edge_seen && !sense_q) |=> !cpu_request;
  endproperty
  a_edge_ack_drops: assert property (p_edge_ack_drops) // see (RQ11)
    else $error("edge mode ack left cpu request up");

  // break with clears allowed lets a software ack through
  property p_break_allows;
    ack_write && break_state && break_clear_enable && !edge_seen |=> !latch_q;
  endproperty
  a_break_allows: assert property (p_break_allows) // see (RQ20)
    else $error("allowed break clear did not clear latch");

  // level mode: an unmasked low pin keeps the cpu request up
  property p_level_request;
    sense_q && low_any && !mask_q |=> cpu_request;
  endproperty
  a_level_request: assert property (p_level_request) // see (RQ5)
    else $error("level mode low pin gave no cpu request");

  // unmapped reads answer zero
  property p_unmapped_read;
    bus_request.read && bus_request.addr != keypad_pkg::STATUS_CONTROL_OFFSET
      && bus_request.addr != keypad_pkg::PIN_ENABLE_OFFSET |=> read_data == keypad_pkg::UNMAPPED_READ;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // see (RQ15)
    else $error("unmapped read returned data");

  // read data stands one cycle only
  property p_read_once;
    !bus_request.read |=> read_data == keypad_pkg::UNMAPPED_READ;
  endproperty
  a_read_once: assert property (p_read_once) // see (RQ15)
    else $error("read data stood past its cycle");

endmodule // keypad_edge_level_interrupt

/* File: verif/keypad_switches.sv */
// behavioural keypad switches on the eight input pins
`timescale 1ns/1ns
module keypad_switches (
  input wire logic clock,
  input wire logic [7:0] press,
  input wire logic [7:0] pullup_enable,
  output logic [7:0] pins
);
  logic [7:0] float_q = 8'h5a;
  // a floating pin shows a pattern that changes every cycle
  always @(posedge clock) float_q <= ~float_q;
  // a pressed key grounds its pin, else pullup or float
  assign pins = ~press & (pullup_enable | float_q);
endmodule // keypad_switches

/* File: verif/keypad_edge_level_interrupt_tb.sv */
// self-checking bench for the keypad interrupt block
`timescale 1ns/1ns
module keypad_edge_level_interrupt_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  keypad_pkg::bus_request_type bus_request = '0;
  logic [7:0] read_data, pins, pullup_enable, force_input;
  logic [7:0] press = 8'h00;
  logic vector_fetch_ack = 1'b0, break_state = 1'b0, break_clear_enable = 1'b0, cpu_request;
  int err_total = 0, n_tests = 0, cycles = 0;
  int en = 0, mask = 0, sense = 0, latch = 0;

  keypad_edge_level_interrupt dut (.clock(clock), .reset(reset), .bus_request(bus_request),
    .read_data(read_data), .keypad_input_pins(pins), .vector_fetch_ack(vector_fetch_ack),
    .break_state(break_state), .break_clear_enable(break_clear_enable), .cpu_request(cpu_request),
    .pullup_enable(pullup_enable), .force_input(force_input));
  keypad_switches keys (.clock(clock), .press(press), .pullup_enable(pullup_enable), .pins(pins));

  // clock and cycle ceiling
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      finish_test();
    end
  end

  // combined low of the enabled pins
  function automatic int low(input logic [7:0] p);
    return int'((p & 8'(en)) != 8'h00);
  endfunction

  // expected status read: pending, ack reads zero, mask, sense
  function automatic logic [7:0] st();
    return {4'h0, 1'(latch | (sense & low(press))), 1'b0, 1'(mask), 1'(sense)};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_request <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clock);
    bus_request <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_request <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clock);
    bus_request <= '0;
    #1 check(read_data, exp);
    @(posedge clock);
    #1 check(read_data, 8'h00);
  endtask

  // one random action, then compare request and status with the model
  task automatic step();
    int k, b, c;
    logic [7:0] p;
    k = $urandom_range(4, 0);
    b = $urandom_range(1, 0);
    c = $urandom_range(1, 0);
    p = 8'($urandom & $urandom);
    @(posedge clock);
    break_state <= 1'(b);
    break_clear_enable <= 1'(c);
    case (k)
      0, 1: begin
        if (low(p) != 0 && low(press) == 0) latch = 1;
        press <= p;
      end
      2: begin
        if (!(b != 0 && c == 0)) latch = 0;
        bus_request <= '{addr: 4'h0, wdata: 8'(4 | 2 * mask | sense), write: 1'b1, read: 1'b0};
      end
      3: begin
        latch = 0;
        vector_fetch_ack <= 1'b1;
      end
      default: begin
        mask = int'(mask == 0);
        bus_request <= '{addr: 4'h0, wdata: 8'(2 * mask | sense), write: 1'b1, read: 1'b0};
      end
    endcase
    @(posedge clock);
    bus_request <= '0;
    vector_fetch_ack <= 1'b0;
    repeat (5) @(posedge clock);
    #1 check(8'(cpu_request), 8'(mask == 0 && (latch != 0 || (sense & low(press)) != 0)));
    rd(4'h0, st());
  endtask

  // main sequence
  initial begin
    void'($urandom(90386));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    rd(4'h1, 8'h00);
    check(pullup_enable, 8'h00);
    for (int s = 0; s < 2; s++) begin
      sense = s;
      en = $urandom_range(255, 1);
      @(posedge clock);
      press <= 8'h00;
      break_state <= 1'b0; // leave break so the ack lands
      break_clear_enable <= 1'b0;
      wr(4'h0, 8'(2 | sense));
      wr(4'h1, 8'(en));
      #1 check(pullup_enable, 8'(en));
      check(force_input, 8'(en));
      repeat (4) @(posedge clock);
      wr(4'h0, 8'(6 | sense));
      wr(4'h0, 8'(sense));
      mask = 0;
      latch = 0;
      rd(4'h1, 8'(en));
      repeat (30) step();
    end
    // hold every key in level mode, unmasked, then reset
    wr(4'h0, 8'h01);
    @(posedge clock);
    press <= 8'hff;
    repeat (5) @(posedge clock);
    #1 check(8'(cpu_request), 8'h01);
    rd(4'h0, 8'h09);
    @(posedge clock);
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    #1 check(8'(cpu_request), 8'h00);
    rd(4'h0, 8'h00);
    finish_test();
  end
endmodule // keypad_edge_level_interrupt_tb
